// *** design/drl_ctrl.sv ***
// Purpose: Per-channel lock, reference select, power-down and wiper decode of a ladder DAC.
// Assumes: Serial pins and program pin are asynchronous; stored values are on clk.
// Notes: resetn stands for power-on and brown-out reset.
// How it works
// - Lock register sixteen bits; quad upper half zero
// - Pair 11 blocks code and configuration writes
// - Pair 10 blocks code writes only
// - Pair 01 blocks configuration writes only
// - Pair 00 leaves everything writable
// - Power-down select bits are never locked
// - Eight independent channels in octal, four in quad, each fully separate
// - Code register selects the ladder tap directly
// - Highest tap is element count minus one
// - Power-down opens the reference switch
// - Two-bit field picks one of four sources
// - Reset loads reference select from stored value
// - Supply source keeps reference pin disconnected
// - Supply source forces unity gain
// - Lock register writes need program pin high
`timescale 1ns/10ps
`include "drl_regs.svh"
module drl_ctrl #(
    parameter bit OCTAL = 1'b1,
    parameter int RES_BITS = 12
) (
    // Clock and reset
    input wire logic clk,
    input wire logic resetn,
    // Serial pins
    input wire logic spiSck,
    input wire logic spiCsN,
    input wire logic spiMosi,
    output logic spiMiso,
    output logic spiMisoOe,
    // Program pin and stored values
    input wire logic highVoltageProgramPin,
    input wire logic [15:0] nvRefSel,
    input wire logic [15:0] nvLock,
    // Ladder controls
    output logic [`DRL_CH_NUM*`DRL_CODE_W-1:0] wiperTap,
    output logic [`DRL_CH_NUM*4-1:0] refSrcSel,
    output logic [`DRL_CH_NUM-1:0] refSwitchClosed,
    output logic [`DRL_CH_NUM-1:0] gainEff,
    output logic [15:0] pwrdnMode
);
    localparam logic [`DRL_CODE_W-1:0] CODE_MASK = `DRL_CODE_W'((1 << RES_BITS) - 1);
    localparam logic [15:0] MASK2 = OCTAL ? `DRL_MASK_OCTAL2 : `DRL_MASK_QUAD2;
    localparam logic [7:0] MASK1 = OCTAL ? `DRL_MASK_OCTAL1 : `DRL_MASK_QUAD1;

    logic [`DRL_CODE_W-1:0] code_reg [`DRL_CH_NUM];
    logic [15:0] refSel_reg;
    logic [15:0] pwrdn_reg;
    logic [7:0] gain_reg;
    logic [15:0] lock_reg;
    logic startup_reg;
    logic [1:0] hvSync_reg;
    logic wrStb;
    logic [`DRL_ADDR_W-1:0] regAddr;
    logic [`DRL_DATA_W-1:0] wrData;
    logic [`DRL_DATA_W-1:0] rdData;
    logic [15:0] refSel_next;
    logic [7:0] gain_next;
    logic [`DRL_CH_NUM*`DRL_CODE_W-1:0] codeFlat;

    // Lock pair decode: upper bit guards code, lower bit guards configuration
    function automatic logic codeLocked(input logic [15:0] lk, input int ch);
        codeLocked = lk[2*ch+1];
    endfunction

    function automatic logic cfgLocked(input logic [15:0] lk, input int ch);
        cfgLocked = lk[2*ch];
    endfunction

    drl_spi u_spi (
        .clk(clk),
        .resetn(resetn),
        .spiSck(spiSck),
        .spiCsN(spiCsN),
        .spiMosi(spiMosi),
        .spiMiso(spiMiso),
        .spiMisoOe(spiMisoOe),
        .wrStb(wrStb),
        .regAddr(regAddr),
        .wrData(wrData),
        .rdData(rdData)
    );

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            hvSync_reg <= 2'h0;
        end else begin
            hvSync_reg <= {hvSync_reg[0], highVoltageProgramPin};
        end
    end

    // Stored values are taken one edge after release, never under reset itself
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            startup_reg <= 1'b1;
        end else begin
            startup_reg <= 1'b0;
        end
    end

    // Code registers, one per channel
    genvar gc;
    generate
        for (gc = 0; gc < `DRL_CH_NUM; gc++) begin : g_code
            always_ff @(posedge clk or negedge resetn) begin
                if (!resetn) begin
                    code_reg[gc] <= `DRL_CODE_POR;
                end else if (wrStb && regAddr == `DRL_REG_CODE0 + 5'(gc)
                             && (OCTAL || gc < 4) && !codeLocked(lock_reg, gc)) begin
                    code_reg[gc] <= wrData[`DRL_CODE_W-1:0] & CODE_MASK;
                end
            end
            assign codeFlat[gc*`DRL_CODE_W +: `DRL_CODE_W] = code_reg[gc];
        end
    endgenerate

    // Per-channel merge of configuration writes with the lock pair
    always_comb begin
        refSel_next = refSel_reg;
        gain_next = gain_reg;
        for (int ch = 0; ch < `DRL_CH_NUM; ch++) begin
            if (!cfgLocked(lock_reg, ch)) begin
                refSel_next[2*ch +: 2] = wrData[2*ch +: 2];
                gain_next[ch] = wrData[`DRL_GAIN_LSB + ch];
            end
        end
        refSel_next = refSel_next & MASK2;
        gain_next = gain_next & MASK1;
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            refSel_reg <= 16'h0000;
        end else if (startup_reg) begin
            refSel_reg <= nvRefSel & MASK2;
        end else if (wrStb && regAddr == `DRL_REG_REFSEL) begin
            refSel_reg <= refSel_next;
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            gain_reg <= `DRL_GAIN_POR;
        end else if (wrStb && regAddr == `DRL_REG_GAIN) begin
            gain_reg <= gain_next;
        end
    end

    // Power-down has no lock so a locked channel can still be woken
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            pwrdn_reg <= `DRL_PWRDN_POR;
        end else if (wrStb && regAddr == `DRL_REG_PWRDN) begin
            pwrdn_reg <= wrData & MASK2;
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            lock_reg <= 16'h0000;
        end else if (startup_reg) begin
            lock_reg <= nvLock & MASK2;
        end else if (wrStb && regAddr == `DRL_REG_LOCK && hvSync_reg[1]) begin
            lock_reg <= wrData & MASK2;
        end
    end

    always_comb begin
        rdData = 16'h0000;
        case (regAddr)
            `DRL_REG_REFSEL: rdData = refSel_reg;
            `DRL_REG_PWRDN: rdData = pwrdn_reg;
            `DRL_REG_GAIN: rdData = {gain_reg, 8'h00};
            `DRL_REG_LOCK: rdData = lock_reg;
            default: begin
                if (regAddr < `DRL_REG_REFSEL) begin
                    rdData = {4'h0, code_reg[regAddr[2:0]]};
                end
            end
        endcase
    end

    // Ladder controls registered; one cycle behind the configuration
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            wiperTap <= '0;
            refSrcSel <= '0;
            refSwitchClosed <= '0;
            gainEff <= '0;
            pwrdnMode <= 16'h0000;
        end else begin
            wiperTap <= codeFlat;
            pwrdnMode <= pwrdn_reg;
            for (int ch = 0; ch < `DRL_CH_NUM; ch++) begin
                refSwitchClosed[ch] <= (pwrdn_reg[2*ch +: 2] == 2'b00)
                                       && (OCTAL || ch < 4);
                gainEff[ch] <= gain_reg[ch]
                               && refSel_reg[2*ch +: 2] != drl_pkg::DRL_REF_VDD;
                refSrcSel[4*ch +: 4] <= 4'h0;
                if (pwrdn_reg[2*ch +: 2] == 2'b00 && (OCTAL || ch < 4)) begin
                    refSrcSel[4*ch + refSel_reg[2*ch +: 2]] <= 1'b1;
                end
            end
        end
    end

    // Checks sit one edge behind the registers they watch, except tapMax_a, quadUpperZero_a and quadChanIdle_a, which check in the same cycle
    generate
        for (gc = 0; gc < `DRL_CH_NUM; gc++) begin : g_chk
            codeLockHold_a: assert property (@(posedge clk) disable iff (!resetn)
                $past(wrStb) && $past(regAddr) == `DRL_REG_CODE0 + 5'(gc)
                && $past(lock_reg[2*gc+1]) |-> $stable(code_reg[gc]))
                else $error("locked code register changed");
            codeWriteTakes_a: assert property (@(posedge clk) disable iff (!resetn)
                wrStb && regAddr == `DRL_REG_CODE0 + 5'(gc) && !lock_reg[2*gc+1]
                && (OCTAL || gc < 4)
                |=> code_reg[gc] == ($past(wrData[`DRL_CODE_W-1:0]) & CODE_MASK))
                else $error("unlocked code write lost");
            cfgLockHold_a: assert property (@(posedge clk) disable iff (!resetn)
                !startup_reg && lock_reg[2*gc] |=> $stable(refSel_reg[2*gc +: 2])
                && $stable(gain_reg[gc]))
                else $error("locked configuration changed");
            refOpen_a: assert property (@(posedge clk) disable iff (!resetn)
                pwrdn_reg[2*gc +: 2] != 2'b00 |=> !refSwitchClosed[gc]
                && refSrcSel[4*gc +: 4] == 4'h0)
                else $error("reference switch closed in power-down");
            gainUnity_a: assert property (@(posedge clk) disable iff (!resetn)
                refSel_reg[2*gc +: 2] == 2'b00 |=> !gainEff[gc])
                else $error("gain above unity on supply source");
            pinIsolated_a: assert property (@(posedge clk) disable iff (!resetn)
                refSel_reg[2*gc +: 2] == 2'b00 |=> refSrcSel[4*gc+2] == 1'b0
                && refSrcSel[4*gc+3] == 1'b0)
                else $error("reference pin tied to supply-sourced ladder");
            tapMax_a: assert property (@(posedge clk) disable iff (!resetn)
                wiperTap[gc*`DRL_CODE_W +: `DRL_CODE_W] <= CODE_MASK)
                else $error("wiper beyond top tap");
            tapFollows_a: assert property (@(posedge clk) disable iff (!resetn)
                wiperTap[gc*`DRL_CODE_W +: `DRL_CODE_W] == $past(code_reg[gc]))
                else $error("wiper tap not following code register");
            srcOneHot_a: assert property (@(posedge clk) disable iff (!resetn)
                pwrdn_reg[2*gc +: 2] == 2'b00 && (OCTAL || gc < 4)
                |=> $onehot(refSrcSel[4*gc +: 4]))
                else $error("reference source not one of four");
            supplyRoute_a: assert property (@(posedge clk) disable iff (!resetn)
                refSel_reg[2*gc +: 2] == 2'b00 && pwrdn_reg[2*gc +: 2] == 2'b00
                && (OCTAL || gc < 4) |=> refSrcSel[4*gc])
                else $error("supply not routed to ladder");
            switchLive_a: assert property (@(posedge clk) disable iff (!resetn)
                pwrdn_reg[2*gc +: 2] == 2'b00 && (OCTAL || gc < 4) |=> refSwitchClosed[gc])
                else $error("reference switch open while powered");
            cfgWriteTakes_a: assert property (@(posedge clk) disable iff (!resetn)
                wrStb && regAddr == `DRL_REG_REFSEL && !lock_reg[2*gc] && !startup_reg
                |=> refSel_reg[2*gc +: 2] == ($past(wrData[2*gc +: 2]) & MASK2[2*gc +: 2]))
                else $error("unlocked reference select write lost");
            gainWriteTakes_a: assert property (@(posedge clk) disable iff (!resetn)
                wrStb && regAddr == `DRL_REG_GAIN && !lock_reg[2*gc]
                |=> gain_reg[gc] == ($past(wrData[`DRL_GAIN_LSB + gc]) && MASK1[gc]))
                else $error("unlocked gain write lost");
            codeQuadOff_a: assert property (@(posedge clk) disable iff (!resetn)
                wrStb && regAddr == `DRL_REG_CODE0 + 5'(gc) && !(OCTAL || gc < 4)
                |=> $stable(code_reg[gc]))
                else $error("absent channel code changed");
        end
    endgenerate

    pwrdnFree_a: assert property (@(posedge clk) disable iff (!resetn)
        wrStb && regAddr == `DRL_REG_PWRDN |=> pwrdn_reg == ($past(wrData) & MASK2))
        else $error("power-down write blocked");
    quadUpperZero_a: assert property (@(posedge clk) disable iff (!resetn)
        !OCTAL |-> lock_reg[15:8] == 8'h00)
        else $error("quad lock upper half nonzero");
    startupLoad_a: assert property (@(posedge clk) disable iff (!resetn)
        startup_reg |=> refSel_reg == ($past(nvRefSel) & MASK2))
        else $error("reference select not loaded at reset");
    lockNeedsHv_a: assert property (@(posedge clk) disable iff (!resetn)
        wrStb && regAddr == `DRL_REG_LOCK && !hvSync_reg[1] && !startup_reg
        |=> $stable(lock_reg))
        else $error("lock changed without program pin");
    lockWriteTakes_a: assert property (@(posedge clk) disable iff (!resetn)
        wrStb && regAddr == `DRL_REG_LOCK && hvSync_reg[1] && !startup_reg
        |=> lock_reg == ($past(wrData) & MASK2))
        else $error("permitted lock write lost");

    // Absent quad channels must stay dark
    quadChanIdle_a: assert property (@(posedge clk) disable iff (!resetn)
        !OCTAL |-> refSwitchClosed[7:4] == 4'h0 && refSrcSel[31:16] == 16'h0000
        && wiperTap[95:48] == 48'h0)
        else $error("absent channel drives ladder");
endmodule

// *** design/drl_pkg.sv ***
// Purpose: Shared types of the ladder control.
// Assumes: Used with drl_regs.svh for constants.
// Notes: Nothing here is imported; users write drl_pkg::name.
package drl_pkg;

    typedef enum logic [1:0] {
        DRL_REF_VDD = 2'b00,
        DRL_REF_BG = 2'b01,
        DRL_REF_PIN = 2'b10,
        DRL_REF_PINBUF = 2'b11
    } drl_ref_t;

    typedef enum logic [1:0] {
        DRL_SPI_IDLE = 2'b00,
        DRL_SPI_CMD = 2'b01,
        DRL_SPI_DATA = 2'b10,
        DRL_SPI_DONE = 2'b11
    } drl_spi_state_t;

endpackage

// *** design/drl_regs.svh ***
// Purpose: Register offsets, field layout, reset values and frame sizes of the ladder control.
// Assumes: Included by bare name; definitions only.
// Notes: One channel owns two adjacent bits in every two-bit-per-channel register.
`ifndef DRL_REGS_SVH
`define DRL_REGS_SVH

`define DRL_CH_NUM 8
`define DRL_CODE_W 12
`define DRL_ADDR_W 5
`define DRL_DATA_W 16

`define DRL_REG_CODE0 5'h00
`define DRL_REG_REFSEL 5'h08
`define DRL_REG_PWRDN 5'h09
`define DRL_REG_GAIN 5'h0A
`define DRL_REG_LOCK 5'h1B

`define DRL_CODE_POR 12'h000
`define DRL_PWRDN_POR 16'h0000
`define DRL_GAIN_POR 8'h00
`define DRL_MASK_OCTAL2 16'hFFFF
`define DRL_MASK_QUAD2 16'h00FF
`define DRL_MASK_OCTAL1 8'hFF
`define DRL_MASK_QUAD1 8'h0F
`define DRL_GAIN_LSB 8

`define DRL_FRAME_BITS 5'd24
`define DRL_CMD_BITS 5'd8
`define DRL_CMD_WRITE 2'h0
`define DRL_CMD_READ 2'h3

`endif

// *** design/drl_spi.sv ***
// Purpose: Serial slave, mode 00, oversampled on clk; 8-bit command then 16 data bits.
// Assumes: Serial clock well below a quarter of clk.
// Notes: A write surfaces as a one-cycle strobe after the 24th rising serial edge.
`timescale 1ns/10ps
`include "drl_regs.svh"
module drl_spi (
    // Clock and reset
    input wire logic clk,
    input wire logic resetn,
    // Serial pins
    input wire logic spiSck,
    input wire logic spiCsN,
    input wire logic spiMosi,
    output logic spiMiso,
    output logic spiMisoOe,
    // Register side
    output logic wrStb,
    output logic [`DRL_ADDR_W-1:0] regAddr,
    output logic [`DRL_DATA_W-1:0] wrData,
    input wire logic [`DRL_DATA_W-1:0] rdData
);
    logic [2:0] sckSync_reg;
    logic [1:0] csSync_reg;
    logic [1:0] mosiSync_reg;
    logic [4:0] bitCnt_reg;
    logic [`DRL_DATA_W-1:0] shift_reg;
    logic [`DRL_DATA_W-1:0] tx_reg;
    logic [1:0] cmd_reg;
    drl_pkg::drl_spi_state_t state_reg;
    logic sckRise;
    logic sckFall;
    logic csActive;
    logic bitIn;

    // Third sck stage only feeds edge detection; first stages stay clean
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            sckSync_reg <= 3'h0;
            csSync_reg <= 2'h3;
            mosiSync_reg <= 2'h0;
        end else begin
            sckSync_reg <= {sckSync_reg[1:0], spiSck};
            csSync_reg <= {csSync_reg[0], spiCsN};
            mosiSync_reg <= {mosiSync_reg[0], spiMosi};
        end
    end

    assign sckRise = sckSync_reg[1] & ~sckSync_reg[2];
    assign sckFall = ~sckSync_reg[1] & sckSync_reg[2];
    assign csActive = ~csSync_reg[1];
    assign bitIn = mosiSync_reg[1];

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            state_reg <= drl_pkg::DRL_SPI_IDLE;
            bitCnt_reg <= 5'h00;
            shift_reg <= 16'h0000;
            cmd_reg <= 2'h0;
            regAddr <= 5'h00;
            wrData <= 16'h0000;
            wrStb <= 1'b0;
        end else begin
            wrStb <= 1'b0;
            if (!csActive) begin
                state_reg <= drl_pkg::DRL_SPI_IDLE;
                bitCnt_reg <= 5'h00;
            end else if (sckRise) begin
                shift_reg <= {shift_reg[14:0], bitIn};
                bitCnt_reg <= bitCnt_reg + 5'h01;
                case (state_reg)
                    drl_pkg::DRL_SPI_IDLE,
                    drl_pkg::DRL_SPI_CMD: begin
                        state_reg <= drl_pkg::DRL_SPI_CMD;
                        if (bitCnt_reg == `DRL_CMD_BITS - 5'd1) begin
                            regAddr <= shift_reg[6:2];
                            cmd_reg <= shift_reg[1:0];
                            state_reg <= drl_pkg::DRL_SPI_DATA;
                        end
                    end
                    drl_pkg::DRL_SPI_DATA: begin
                        if (bitCnt_reg == `DRL_FRAME_BITS - 5'd1) begin
                            state_reg <= drl_pkg::DRL_SPI_DONE;
                            if (cmd_reg == `DRL_CMD_WRITE) begin
                                wrStb <= 1'b1;
                                wrData <= {shift_reg[14:0], bitIn};
                            end
                        end
                    end
                    drl_pkg::DRL_SPI_DONE: begin
                        state_reg <= drl_pkg::DRL_SPI_DONE;
                    end
                    default: begin
                        state_reg <= drl_pkg::DRL_SPI_IDLE;
                    end
                endcase
            end
        end
    end

    // Read data loads one cycle after the command byte, well before the next falling edge
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            tx_reg <= 16'h0000;
            spiMiso <= 1'b0;
        end else if (!csActive) begin
            spiMiso <= 1'b0;
        end else if (state_reg == drl_pkg::DRL_SPI_DATA && bitCnt_reg == `DRL_CMD_BITS
                     && !sckRise && !sckFall && cmd_reg == `DRL_CMD_READ
                     && tx_reg == 16'h0000 && spiMiso == 1'b0) begin
            spiMiso <= rdData[15];
            tx_reg <= {rdData[14:0], 1'b0};
        end else if (sckFall && state_reg == drl_pkg::DRL_SPI_DATA
                     && bitCnt_reg > `DRL_CMD_BITS) begin
            spiMiso <= tx_reg[15];
            tx_reg <= {tx_reg[14:0], 1'b0};
        end else if (state_reg != drl_pkg::DRL_SPI_DATA) begin
            tx_reg <= 16'h0000;
        end
    end

    assign spiMisoOe = csActive;

    wrOnFrameEnd_a: assert property (@(posedge clk) disable iff (!resetn)
        wrStb |-> $past(bitCnt_reg) == `DRL_FRAME_BITS - 5'd1 && $past(sckRise))
        else $error("write strobe outside frame end");
endmodule

// *** dv/drl_host_model.sv ***
// Purpose: Serial host that frames register reads and writes for the ladder control.
// Assumes: Mode 00, MSB first, 24 bits a frame; moves its pins on falling clk edges.
// Notes: Serial clock 11 clk a period, so the slave's sync lag always fits.
`timescale 1ns/10ps
module drl_host_model (
    // Clock
    input wire logic clk,
    // Serial pins
    output logic spiSck,
    output logic spiCsN,
    output logic spiMosi,
    input wire logic spiMiso
);
    initial begin
        spiSck = 1'b0;
        spiCsN = 1'b1;
        spiMosi = 1'b0;
    end

    // Read data is taken just before each rising serial edge
    task automatic xfer(input logic [4:0] a, input logic [1:0] c, input logic [15:0] d,
                        output logic [15:0] q);
        logic [23:0] w;
        w = {a, c, 1'b0, d};
        q = 16'h0000;
        @(negedge clk);
        spiCsN = 1'b0;
        for (int i = 23; i >= 0; i--) begin
            spiMosi = w[i];
            repeat (5) @(negedge clk);
            q = {q[14:0], spiMiso};
            spiSck = 1'b1;
            repeat (6) @(negedge clk);
            spiSck = 1'b0;
        end
        repeat (2) @(negedge clk);
        spiCsN = 1'b1;
        // Released data line shows no stale bit
        spiMosi = ~spiMosi;
        repeat (6) @(negedge clk);
    endtask
endmodule

// *** dv/testbench.sv ***
// Purpose: Self-checking bench for lock, reference select, power-down and wiper decode.
// Assumes: Octal part at 12 bits beside a quad at 8 bits; program pin high unless lowered.
// Notes: Rows cover the four lock pairs; reset and odd cases follow by hand.
`timescale 1ns/10ps
`include "drl_regs.svh"
module testbench;
    typedef struct packed {
        logic [1:0] pair;
        logic [11:0] code;
        logic [3:0] ref1;
    } drl_row_t;

    logic clk;
    logic resetn;
    logic spiSck, spiCsN, spiMosi, spiMiso, spiMisoOe;
    logic highVoltageProgramPin;
    logic [15:0] nvRefSel, nvLock, pwrdnMode, rdv;
    logic [95:0] wiperTap;
    logic [31:0] refSrcSel;
    logic [7:0] refSwitchClosed, gainEff;
    logic [95:0] quadTap;
    logic [31:0] quadSrc;
    logic [7:0] quadClosed, quadGain;
    int badCount = 0;
    int checkCount = 0;
    drl_row_t rows [4] = '{
        '{2'b00, 12'hABC, 4'h2},
        '{2'b01, 12'hABC, 4'h1},
        '{2'b10, 12'h000, 4'h2},
        '{2'b11, 12'h000, 4'h1}
    };

    drl_ctrl #(.OCTAL(1'b1), .RES_BITS(12)) uut (
        .clk(clk), .resetn(resetn),
        .spiSck(spiSck), .spiCsN(spiCsN), .spiMosi(spiMosi),
        .spiMiso(spiMiso), .spiMisoOe(spiMisoOe),
        .highVoltageProgramPin(highVoltageProgramPin),
        .nvRefSel(nvRefSel), .nvLock(nvLock),
        .wiperTap(wiperTap), .refSrcSel(refSrcSel), .refSwitchClosed(refSwitchClosed),
        .gainEff(gainEff), .pwrdnMode(pwrdnMode)
    );

    // Quad part on the same serial lines; its data-out stays unused
    drl_ctrl #(.OCTAL(1'b0), .RES_BITS(8)) uutQuad (
        .clk(clk), .resetn(resetn),
        .spiSck(spiSck), .spiCsN(spiCsN), .spiMosi(spiMosi),
        .spiMiso(), .spiMisoOe(),
        .highVoltageProgramPin(highVoltageProgramPin),
        .nvRefSel(nvRefSel), .nvLock(nvLock),
        .wiperTap(quadTap), .refSrcSel(quadSrc), .refSwitchClosed(quadClosed),
        .gainEff(quadGain), .pwrdnMode()
    );

    drl_host_model host (
        .clk(clk), .spiSck(spiSck), .spiCsN(spiCsN), .spiMosi(spiMosi), .spiMiso(spiMiso)
    );

    initial clk = 1'b0;
    always #20 clk = ~clk;

    task automatic check(input logic [95:0] got, input logic [95:0] exp);
        checkCount++;
        if (got !== exp) begin
            badCount++;
            $display("wrong value at %0t: got %0h expected %0h", $time, got, exp);
        end
    endtask

    task automatic wr(input logic [4:0] a, input logic [15:0] d);
        logic [15:0] q;
        host.xfer(a, `DRL_CMD_WRITE, d, q);
    endtask

    task automatic rd(input logic [4:0] a, output logic [15:0] q);
        fork
            host.xfer(a, `DRL_CMD_READ, 16'h0000, q);
            begin
                repeat (20) @(negedge clk);
                check(spiMisoOe, 1'b1);
            end
        join
    endtask

    task automatic printVerdict();
        if (badCount == 0 && checkCount > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    // Whole plan needs about 12600 clk
    initial begin
        repeat (60000) @(posedge clk);
        badCount++;
        printVerdict();
    end

    initial begin
        resetn = 1'b0;
        highVoltageProgramPin = 1'b1;
        nvRefSel = 16'h00E4;
        nvLock = 16'h0000;
        repeat (8) @(negedge clk);
        resetn = 1'b1;
        repeat (4) @(negedge clk);
        check(refSrcSel, 32'h1111_8421);
        check(spiMisoOe, 1'b0);
        foreach (rows[i]) begin
            wr(`DRL_REG_LOCK, 16'h0000);
            wr(`DRL_REG_CODE0 + 5'd1, 16'h0000);
            wr(`DRL_REG_REFSEL, 16'h0000);
            wr(`DRL_REG_LOCK, {12'h000, rows[i].pair, 2'b00});
            wr(`DRL_REG_CODE0 + 5'd1, 16'h0ABC);
            wr(`DRL_REG_REFSEL, 16'h0004);
            wr(`DRL_REG_PWRDN, 16'h0004);
            check(wiperTap[23:12], rows[i].code);
            check(quadTap[23:12], rows[i].code & 12'h0FF);
            check(pwrdnMode, 16'h0004);
            check(refSwitchClosed, 8'hFD);
            check(refSrcSel[7:4], 4'h0);
            wr(`DRL_REG_PWRDN, 16'h0000);
            check(refSrcSel[7:4], rows[i].ref1);
        end
        wr(`DRL_REG_LOCK, 16'hFFFF);
        rd(`DRL_REG_LOCK, rdv);
        check(rdv, 16'hFFFF);
        highVoltageProgramPin = 1'b0;
        wr(`DRL_REG_LOCK, 16'h0000);
        rd(`DRL_REG_LOCK, rdv);
        check(rdv, 16'hFFFF);
        highVoltageProgramPin = 1'b1;
        wr(`DRL_REG_LOCK, 16'h0000);
        wr(`DRL_REG_CODE0 + 5'd7, 16'h0FFF);
        check(wiperTap[95:84], 12'hFFF);
        check(wiperTap[23:12], 12'h000);
        check(quadTap[95:84], 12'h000);
        // Pin modes named outright: ch1 band gap, ch2 unbuffered, ch3 buffered, others supply
        wr(`DRL_REG_REFSEL, 16'h00E4);
        wr(`DRL_REG_GAIN, 16'hFF00);
        check(refSrcSel, 32'h1111_8421);
        check(gainEff, 8'h0E);
        check(quadSrc, 32'h0000_8421);
        check(quadGain, 8'h0E);
        check(quadClosed, 8'h0F);
        rd(5'h1F, rdv);
        check(rdv, 16'h0000);
        // Mid-run reset reloads stored select and lock words
        nvRefSel = 16'h1B00;
        nvLock = 16'h00C3;
        resetn = 1'b0;
        repeat (2) @(negedge clk);
        check(wiperTap, 96'h0);
        resetn = 1'b1;
        repeat (4) @(negedge clk);
        check(refSrcSel, 32'h1248_1111);
        check(quadSrc, 32'h0000_1111);
        rd(`DRL_REG_LOCK, rdv);
        check(rdv, 16'h00C3);
        wr(`DRL_REG_CODE0, 16'h0555);
        wr(`DRL_REG_CODE0 + 5'd1, 16'h0333);
        check(wiperTap[23:0], 24'h333000);
        check(quadTap[23:0], 24'h033000);
        // Config-locked ch0 and ch3 keep supply select and their gain bit
        wr(`DRL_REG_REFSEL, 16'hFFFF);
        wr(`DRL_REG_GAIN, 16'hFF00);
        check(refSrcSel, 32'h8888_1881);
        check(gainEff, 8'hF6);
        check(quadSrc, 32'h0000_1881);
        check(quadGain, 8'h06);
        printVerdict();
    end
endmodule
